// ==== common/gdsc_pkg.sv ====
package gdsc_pkg;

   // Register indices on the internal register port
   localparam logic [4:0]  ADDR_ERR     = 5'h13;
   localparam logic [4:0]  ADDR_CFG     = 5'h14;
   localparam logic [4:0]  ADDR_ADV     = 5'h15;
   localparam logic [4:0]  ADDR_BND     = 5'h16;

   // Error register bit positions
   localparam int          ERR_VTO_BIT  = 9;
   localparam int          ERR_AOV_BIT  = 6;
   localparam int          ERR_AUV_BIT  = 5;
   localparam int          ERR_CLS_BIT  = 4;
   localparam int          LMI_BIT      = 1;
   localparam int          PAR_BIT      = 0;

   // Config field layout: stored bits 15:4
   localparam int          CFG_LSB      = 4;
   localparam logic [15:0] CFG_RESET    = 16'hC111;

   // Verification timeout figures
   localparam int          VTO_REG_MS   = 15;
   localparam int          VTO_LONG_MS  = 60;
   localparam int          CLK_KHZ      = 100000;
   localparam int          VTO_W        = 23;

   typedef enum logic [1:0] {
      CLAMP_LOW,
      CLAMP_HIGH,
      CLAMP_SAFE,
      CLAMP_REGULAR
   } gdsc_clamp_e;

   typedef enum logic [1:0] {
      DIO_INPUT,
      DIO_MIRROR,
      DIO_RSVD2,
      DIO_RSVD3
   } gdsc_dio_e;

   typedef struct packed {
      gdsc_clamp_e clampMode;
      logic        ocSel;
      logic        lockSel;
      logic        satSel;
      logic        toLong;
      logic        pulse_suppressor_enable;
      logic        clampEn;
      gdsc_dio_e   dioMode;
      logic        advWe;
      logic        beComp;
   } gdsc_cfg_s;

   typedef struct packed {
      logic vto;
      logic aov;
      logic auv;
      logic cls;
   } gdsc_err_s;

endpackage

// ==== hdl/gdsc_regs.sv ====
`timescale 1ns/1ns
// Overview of operation
// - Verification timeout event sets sticky error bit 9 until cleared.
// - Upper ADC boundary violation sets sticky error bit 6.
// - Lower ADC boundary violation sets sticky error bit 5.
// - Detected loss of primary communication sets sticky error bit 4.
// - Error bits 8:7 and bits 3:2 of both registers read zero.
// - Bit 1 of every read word shows whether last message was discarded.
// - Bit 0 of every read word is a device-computed parity bit.
// - Config bits 15:14 select clamp inhibit pin behaviour, four modes.
// - Config bit 13 picks overcurrent comparator threshold.
// - Config bit 12 picks secondary lockout threshold.
// - Config bit 11 picks saturation detection threshold.
// - Config bit 10 picks verification timeout 15 ms or 60 ms.
// - Config bit 9 enables the pulse suppressor.
// - Config bit 8 clamps saturation pin to ground while PWM is off.
// - Config bits 7:6: 00 input, 01 mirror first digital pin.
// - Config bit 5 clear discards advanced and boundary register writes.
// - Leaving configuration mode clears advanced write enable automatically.
// - Config bit 4 enables base-emitter compensation of plateau levels.
module gdsc_regs
   import gdsc_pkg::*;
#(
   parameter int unsigned VTO_REG_CYC  = VTO_REG_MS * CLK_KHZ,
   parameter int unsigned VTO_LONG_CYC = VTO_LONG_MS * CLK_KHZ
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             regWrite,
   input  wire logic             regRead,
   input  wire logic [4:0]       regAddr,
   input  wire logic [15:0]      regWdata,
   input  wire logic             msgDone,
   input  wire logic             msgBad,
   input  wire logic             verifyTimeoutEvt,
   input  wire logic             adcOverEvt,
   input  wire logic             adcUnderEvt,
   input  wire logic             commLossEvt,
   input  wire logic             configModeActive,
   input  wire logic             pwmOn,
   input  wire logic             safeTurnOff,
   input  wire logic             regularTurnOff,
   input  wire logic             digitalIoOnePin,
   output logic [15:0]           regRdata,
   output logic                  regRvalid,
   output logic                  advWriteStrobe,
   output logic [4:0]            advWriteAddr,
   output logic [15:0]           advWriteData,
   output logic                  advWriteDiscard,
   output logic                  clampInhibitPin,
   output logic                  overcurrentThresholdSelect,
   output logic                  lockoutThresholdSelect,
   output logic                  saturationThresholdSelect,
   output logic [VTO_W-1:0]      verifyTimeoutLimit,
   output logic                  pulseSuppressorEnable,
   output logic                  saturationPinClamp,
   output logic                  digitalIoTwoOut,
   output logic                  digitalIoTwoOe,
   output logic                  baseEmitterCompEnable
);

   gdsc_cfg_s   cfg;
   gdsc_err_s   err;
   logic        lastMessageInvalid;
   logic        cfgModeDly;
   logic        dioSync1;
   logic        dioSync2;
   logic [15:0] next_word;
   logic        wrErr;
   logic        wrCfg;
   logic        wrAdv;
   logic        modeLeft;
   logic        next_clamp;

   assign wrErr    = regWrite && (regAddr == ADDR_ERR);
   assign wrCfg    = regWrite && (regAddr == ADDR_CFG);
   assign wrAdv    = regWrite && ((regAddr == ADDR_ADV) || (regAddr == ADDR_BND));
   assign modeLeft = cfgModeDly && !configModeActive;

   // Sticky flags: event wins over a clear in the same cycle; write 1 clears
   always_ff @(posedge mclk) begin
      if (rst) begin
         err <= '0;
      end else begin
         err.vto <= verifyTimeoutEvt | (err.vto & ~(wrErr & regWdata[ERR_VTO_BIT]));
         err.aov <= adcOverEvt | (err.aov & ~(wrErr & regWdata[ERR_AOV_BIT]));
         err.auv <= adcUnderEvt | (err.auv & ~(wrErr & regWdata[ERR_AUV_BIT]));
         err.cls <= commLossEvt | (err.cls & ~(wrErr & regWdata[ERR_CLS_BIT]));
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lastMessageInvalid <= 1'b0;
      end else if (msgDone) begin
         lastMessageInvalid <= msgBad;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cfgModeDly <= 1'b0;
      end else begin
         cfgModeDly <= configModeActive;
      end
   end

   // Mode exit clear beats a simultaneous software set of the enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg <= gdsc_cfg_s'(CFG_RESET[15:CFG_LSB]);
      end else begin
         if (wrCfg) begin
            cfg <= gdsc_cfg_s'(regWdata[15:CFG_LSB]);
         end
         if (modeLeft) begin
            cfg.advWe <= 1'b0;
         end
      end
   end

   // Advanced and boundary register writes pass only while enabled
   always_ff @(posedge mclk) begin
      if (rst) begin
         advWriteStrobe  <= 1'b0;
         advWriteDiscard <= 1'b0;
         advWriteAddr    <= '0;
         advWriteData    <= '0;
      end else begin
         advWriteStrobe  <= wrAdv && cfg.advWe;
         advWriteDiscard <= wrAdv && !cfg.advWe;
         if (wrAdv) begin
            advWriteAddr <= regAddr;
            advWriteData <= regWdata;
         end
      end
   end

   // Read word assembly, reserved bits left at zero
   always_comb begin
      next_word = 16'h0000;
      case (regAddr)
         ADDR_ERR: begin
            next_word[ERR_VTO_BIT] = err.vto;
            next_word[ERR_AOV_BIT] = err.aov;
            next_word[ERR_AUV_BIT] = err.auv;
            next_word[ERR_CLS_BIT] = err.cls;
         end
         ADDR_CFG: begin
            next_word[15:CFG_LSB] = cfg;
         end
         default: begin
            next_word = 16'h0000;
         end
      endcase
      next_word[LMI_BIT] = lastMessageInvalid;
      next_word[PAR_BIT] = ~^next_word[15:1];
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         regRdata  <= '0;
         regRvalid <= 1'b0;
      end else begin
         regRvalid <= regRead;
         if (regRead) begin
            regRdata <= next_word;
         end
      end
   end

   always_comb begin
      case (cfg.clampMode)
         CLAMP_LOW:     next_clamp = 1'b0;
         CLAMP_HIGH:    next_clamp = 1'b1;
         CLAMP_SAFE:    next_clamp = safeTurnOff;
         CLAMP_REGULAR: next_clamp = safeTurnOff | regularTurnOff;
         default:       next_clamp = 1'b0;
      endcase
   end

   // First digital pin arrives from outside: two-stage synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         dioSync1 <= 1'b0;
         dioSync2 <= 1'b0;
      end else begin
         dioSync1 <= digitalIoOnePin;
         dioSync2 <= dioSync1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         clampInhibitPin            <= 1'b0;
         overcurrentThresholdSelect <= 1'b0;
         lockoutThresholdSelect     <= 1'b0;
         saturationThresholdSelect  <= 1'b0;
         verifyTimeoutLimit         <= '0;
         pulseSuppressorEnable      <= 1'b0;
         saturationPinClamp         <= 1'b0;
         digitalIoTwoOut            <= 1'b0;
         digitalIoTwoOe             <= 1'b0;
         baseEmitterCompEnable      <= 1'b0;
      end else begin
         clampInhibitPin            <= next_clamp;
         overcurrentThresholdSelect <= cfg.ocSel;
         lockoutThresholdSelect     <= cfg.lockSel;
         saturationThresholdSelect  <= cfg.satSel;
         verifyTimeoutLimit         <= cfg.toLong ? VTO_W'(VTO_LONG_CYC)
                                                  : VTO_W'(VTO_REG_CYC);
         pulseSuppressorEnable      <= cfg.pulse_suppressor_enable;
         saturationPinClamp         <= cfg.clampEn && !pwmOn;
         digitalIoTwoOe             <= (cfg.dioMode == DIO_MIRROR);
         digitalIoTwoOut            <= (cfg.dioMode == DIO_MIRROR) && dioSync2;
         baseEmitterCompEnable      <= cfg.beComp;
      end
   end

   sequence evtSeen(logic e);
      e ##1 1'b1;
   endsequence

   // Input dropped out of configuration mode this cycle
   sequence modeExitSeen;
      $fell(configModeActive);
   endsequence

   chk_vto_sticky: assert property (@(posedge mclk) disable iff (rst)
      err.vto && !(wrErr && regWdata[ERR_VTO_BIT]) |=> err.vto)
      else $error("verify timeout flag dropped without clear");

   chk_aov_set: assert property (@(posedge mclk) disable iff (rst)
      evtSeen(adcOverEvt) |-> err.aov)
      else $error("over boundary event lost");

   chk_auv_set: assert property (@(posedge mclk) disable iff (rst)
      adcUnderEvt |=> err.auv)
      else $error("under boundary event lost");

   chk_cls_setwin: assert property (@(posedge mclk) disable iff (rst)
      commLossEvt && wrErr && regWdata[ERR_CLS_BIT] |=> err.cls)
      else $error("comm loss flag lost to clear");

   chk_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
      regRvalid |-> regRdata[3:2] == 2'b00
         && ($past(regAddr) != ADDR_ERR || regRdata[8:7] == 2'b00))
      else $error("reserved bits read nonzero");

   chk_lmi_read: assert property (@(posedge mclk) disable iff (rst)
      regRead && !msgDone |=> regRdata[LMI_BIT] == $past(lastMessageInvalid))
      else $error("read word lmi mismatch");

   chk_odd_parity: assert property (@(posedge mclk) disable iff (rst)
      regRvalid |-> ^regRdata == 1'b1)
      else $error("read word parity not odd");

   chk_adv_gate: assert property (@(posedge mclk) disable iff (rst)
      wrAdv |=> advWriteStrobe == $past(cfg.advWe) && advWriteDiscard == !$past(cfg.advWe))
      else $error("advanced write gating wrong");

   chk_mode_exit: assert property (@(posedge mclk) disable iff (rst)
      modeExitSeen |=> !cfg.advWe)
      else $error("advanced enable survived mode exit");

   chk_sat_clamp: assert property (@(posedge mclk) disable iff (rst)
      cfg.clampEn && !pwmOn |=> saturationPinClamp)
      else $error("saturation pin not clamped");

   chk_dio_mode: assert property (@(posedge mclk) disable iff (rst)
      cfg.dioMode != DIO_MIRROR |=> !digitalIoTwoOe && !digitalIoTwoOut)
      else $error("digital io two driven outside mirror mode");

   chk_vto_limit: assert property (@(posedge mclk) disable iff (rst)
      cfg.toLong |=> verifyTimeoutLimit == VTO_W'(VTO_LONG_CYC))
      else $error("timeout limit not long");

   chk_vto_short: assert property (@(posedge mclk) disable iff (rst)
      !cfg.toLong |=> verifyTimeoutLimit == VTO_W'(VTO_REG_CYC))
      else $error("timeout limit not regular");

   chk_vto_set: assert property (@(posedge mclk) disable iff (rst)
      verifyTimeoutEvt |=> err.vto)
      else $error("verify timeout event lost");

   chk_cls_set: assert property (@(posedge mclk) disable iff (rst)
      commLossEvt |=> err.cls)
      else $error("comm loss event lost");

   chk_lmi_store: assert property (@(posedge mclk) disable iff (rst)
      msgDone |=> lastMessageInvalid == $past(msgBad))
      else $error("message status not stored");

   chk_err_readback: assert property (@(posedge mclk) disable iff (rst)
      regRead && regAddr == ADDR_ERR |=> regRdata[ERR_VTO_BIT] == $past(err.vto)
         && regRdata[ERR_CLS_BIT] == $past(err.cls))
      else $error("error word readback wrong");

   chk_cfg_readback: assert property (@(posedge mclk) disable iff (rst)
      regRead && regAddr == ADDR_CFG |=> regRdata[15:CFG_LSB] == $past(cfg))
      else $error("config word readback wrong");

   chk_clamp_low: assert property (@(posedge mclk) disable iff (rst)
      cfg.clampMode == CLAMP_LOW |=> !clampInhibitPin)
      else $error("clamp pin not held low");

   chk_clamp_high: assert property (@(posedge mclk) disable iff (rst)
      cfg.clampMode == CLAMP_HIGH |=> clampInhibitPin)
      else $error("clamp pin not held high");

   chk_clamp_safe: assert property (@(posedge mclk) disable iff (rst)
      cfg.clampMode == CLAMP_SAFE |=> clampInhibitPin == $past(safeTurnOff))
      else $error("clamp pin not following safe turn-off");

   chk_clamp_both: assert property (@(posedge mclk) disable iff (rst)
      cfg.clampMode == CLAMP_REGULAR |=> clampInhibitPin == $past(safeTurnOff || regularTurnOff))
      else $error("clamp pin not following both turn-offs");

   chk_oc_select: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> overcurrentThresholdSelect == $past(cfg.ocSel))
      else $error("overcurrent select not following config");

   chk_lock_select: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> lockoutThresholdSelect == $past(cfg.lockSel))
      else $error("lockout select not following config");

   chk_sat_select: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> saturationThresholdSelect == $past(cfg.satSel))
      else $error("saturation select not following config");

   chk_ps_enable: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> pulseSuppressorEnable == $past(cfg.pulse_suppressor_enable))
      else $error("pulse suppressor enable not following config");

   chk_be_comp: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> baseEmitterCompEnable == $past(cfg.beComp))
      else $error("compensation enable not following config");

   chk_sat_release: assert property (@(posedge mclk) disable iff (rst)
      !cfg.clampEn || pwmOn |=> !saturationPinClamp)
      else $error("saturation pin clamped while not allowed");

   chk_dio_mirror: assert property (@(posedge mclk) disable iff (rst)
      cfg.dioMode == DIO_MIRROR |=> digitalIoTwoOe && digitalIoTwoOut == $past(dioSync2))
      else $error("digital io two not mirroring");

   chk_adv_capture: assert property (@(posedge mclk) disable iff (rst)
      wrAdv |=> advWriteAddr == $past(regAddr) && advWriteData == $past(regWdata))
      else $error("advanced write address or data not captured");

endmodule // gdsc_regs

// ==== verif/gdsc_host.sv ====
`timescale 1ns/1ns
module gdsc_host (
   input  wire logic        mclk,
   input  wire logic        regRvalid,
   input  wire logic [15:0] regRdata,
   output logic             regWrite,
   output logic             regRead,
   output logic [4:0]       regAddr,
   output logic [15:0]      regWdata
);
   initial begin
      regWrite = 1'b0;
      regRead  = 1'b0;
      regAddr  = 5'h00;
      regWdata = 16'h0000;
   end

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk) #1;
      regAddr  = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge mclk) #1;
      regWrite = 1'b0;
      // Released lines stop showing the old value
      regAddr  = ~a;
      regWdata = ~d;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
      @(posedge mclk) #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge mclk) #1;
      regRead = 1'b0;
      regAddr = ~a;
      ok = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (regRvalid === 1'b1) ok = 1'b1;
         else @(posedge mclk) #1;
      end
      d  = regRdata;
      ok = ok && (^regRdata === 1'b1);
   endtask
endmodule // gdsc_host

// ==== verif/gdsc_regs_test.sv ====
`timescale 1ns/1ns
module gdsc_regs_test
   import gdsc_pkg::*;
;
   logic mclk, rst, regWrite, regRead, regRvalid, msgDone, msgBad, configModeActive;
   logic pwmOn, safeTurnOff, regularTurnOff, digitalIoOnePin, advWriteStrobe;
   logic advWriteDiscard, clampInhibitPin, overcurrentThresholdSelect;
   logic lockoutThresholdSelect, saturationThresholdSelect, pulseSuppressorEnable;
   logic saturationPinClamp, digitalIoTwoOut, digitalIoTwoOe, baseEmitterCompEnable;
   logic [3:0]       evt;
   logic [4:0]       regAddr, advWriteAddr;
   logic [15:0]      regWdata, regRdata, advWriteData;
   logic [VTO_W-1:0] verifyTimeoutLimit;
   int               nErrors = 0;
   int               checkCount = 0;
   logic [4:0]       ct [6] = '{5'h06, 5'h09, 5'h12, 5'h15, 5'h1B, 5'h18};
   logic [15:0]      fb [4] = '{16'h0010, 16'h0020, 16'h0040, 16'h0200};

   gdsc_regs #(.VTO_REG_CYC(15), .VTO_LONG_CYC(60)) uut (
      .mclk, .rst, .regWrite, .regRead, .regAddr, .regWdata, .msgDone, .msgBad,
      .verifyTimeoutEvt(evt[3]), .adcOverEvt(evt[2]), .adcUnderEvt(evt[1]),
      .commLossEvt(evt[0]), .configModeActive, .pwmOn, .safeTurnOff, .regularTurnOff,
      .digitalIoOnePin, .regRdata, .regRvalid, .advWriteStrobe, .advWriteAddr,
      .advWriteData, .advWriteDiscard, .clampInhibitPin, .overcurrentThresholdSelect,
      .lockoutThresholdSelect, .saturationThresholdSelect, .verifyTimeoutLimit,
      .pulseSuppressorEnable, .saturationPinClamp, .digitalIoTwoOut, .digitalIoTwoOe,
      .baseEmitterCompEnable
   );

   gdsc_host host (
      .mclk, .regRvalid, .regRdata, .regWrite, .regRead, .regAddr, .regWdata
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checkCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Read and compare, parity filled in as an odd-weight word
   task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] w);
      logic [15:0] d;
      logic        ok;
      host.rd(a, d, ok);
      chk({nm, " ok"}, ok, 1'b1);
      chk(nm, d, {w[15:1], ~^w[15:1]});
   endtask

   task automatic wcfg(input logic [15:0] v);
      host.wr(ADDR_CFG, v);
      @(posedge mclk) #1;
   endtask

   task automatic results;
      $display("errors %0d checks %0d", nErrors, checkCount);
      if (nErrors == 0 && checkCount > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      evt = 4'h0;
      {msgDone, msgBad, configModeActive, pwmOn} = 4'h0;
      {safeTurnOff, regularTurnOff, digitalIoOnePin} = 3'h0;
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      @(posedge mclk) #1;
      chk("satClamp", saturationPinClamp, 1'b1);
      chk("beComp", baseEmitterCompEnable, 1'b1);
      chk("limit", verifyTimeoutLimit, 24'h00_000F);
      rdc("cfg reset", ADDR_CFG, 16'hC110);
      pwmOn = 1'b1;
      repeat (2) @(posedge mclk) #1;
      chk("satClamp on", saturationPinClamp, 1'b0);
      pwmOn = 1'b0;
      digitalIoOnePin = 1'b1;
      wcfg(16'h3E60);
      chk("oc", overcurrentThresholdSelect, 1'b1);
      chk("lock", lockoutThresholdSelect, 1'b1);
      chk("sat", saturationThresholdSelect, 1'b1);
      chk("limit", verifyTimeoutLimit, 24'h00_003C);
      chk("ps", pulseSuppressorEnable, 1'b1);
      chk("satClamp off", saturationPinClamp, 1'b0);
      chk("dioOe", digitalIoTwoOe, 1'b1);
      chk("dioOut", digitalIoTwoOut, 1'b1);
      chk("beComp", baseEmitterCompEnable, 1'b0);
      rdc("cfg", ADDR_CFG, 16'h3E60);
      digitalIoOnePin = 1'b0;
      repeat (4) @(posedge mclk) #1;
      chk("dioOut low", digitalIoTwoOut, 1'b0);
      foreach (ct[i]) begin
         {safeTurnOff, regularTurnOff} = ct[i][2:1];
         wcfg({ct[i][4:3], 14'h0000});
         chk("clamp", clampInhibitPin, ct[i][0]);
      end
      chk("limit short", verifyTimeoutLimit, 24'h00_000F);
      host.wr(ADDR_ADV, 16'h1234);
      chk("discard", advWriteDiscard, 1'b1);
      chk("no strobe", advWriteStrobe, 1'b0);
      configModeActive = 1'b1;
      wcfg(16'h0020);
      host.wr(ADDR_BND, 16'hA5A5);
      chk("strobe", advWriteStrobe, 1'b1);
      chk("advAddr", advWriteAddr, ADDR_BND);
      chk("advData", advWriteData, 16'hA5A5);
      rdc("cfg we", ADDR_CFG, 16'h0020);
      configModeActive = 1'b0;
      repeat (2) @(posedge mclk) #1;
      rdc("cfg exit", ADDR_CFG, 16'h0000);
      host.wr(ADDR_ADV, 16'h4321);
      chk("discard exit", advWriteDiscard, 1'b1);
      foreach (fb[i]) begin
         evt = 4'h1 << i;
         @(posedge mclk) #1;
         evt = 4'h0;
         rdc("flag", ADDR_ERR, fb[i]);
         host.wr(ADDR_ERR, fb[i]);
         rdc("flag clear", ADDR_ERR, 16'h0000);
      end
      // Event and clear sampled on the same edge: the event must win
      fork
         host.wr(ADDR_ERR, 16'h0010);
         begin
            @(posedge mclk) #1 evt = 4'h1;
            @(posedge mclk) #1 evt = 4'h0;
         end
      join
      rdc("set wins", ADDR_ERR, 16'h0010);
      evt = 4'hF;
      @(posedge mclk) #1;
      evt = 4'h0;
      rdc("all flags", ADDR_ERR, 16'h0270);
      host.wr(ADDR_ERR, 16'hFFFF);
      wcfg(16'hFFFF);
      rdc("cfg ones", ADDR_CFG, 16'hFFF0);
      chk("dio rsvd", digitalIoTwoOe, 1'b0);
      {msgBad, msgDone} = 2'h3;
      @(posedge mclk) #1;
      {msgBad, msgDone} = 2'h0;
      rdc("lmi cfg", ADDR_CFG, 16'hFFF2);
      rdc("lmi err", ADDR_ERR, 16'h0002);
      rdc("unmapped", 5'h00, 16'h0002);
      msgDone = 1'b1;
      @(posedge mclk) #1;
      msgDone = 1'b0;
      rdc("lmi ok", ADDR_ERR, 16'h0000);
      results();
   end
endmodule // gdsc_regs_test
